/* File: hdl/crs_resampler.sv */
// chroma resampler: 4:4:4 / 4:2:2 / 4:2:0 conversion with apb control
//
// What this block does
// - converts stream between full, half-width and half-width-half-height chroma
// - 4:2:2 keeps full luma, chroma planes at half width
// - 4:2:0 keeps full luma, chroma halved in width and height
// - co-sited samples; horizontal nearest or filtered, vertical nearest only
// - optionally takes width and height from incoming control packets
// - horizontal chroma ratio is exactly two up or two down
// - nearest downsampling drops chroma of even columns, first column is one
// - filtered downsampling applies fixed nine-tap anti-alias filter before decimation
// - filter coefficients near powers of two, shift-add only, no memory
// - nearest upsampling repeats each column pair's Cb and Cr on both columns
// - filtered upsampling: four taps, odd columns pass, even at half phase
// - luma-adaptive mode detects luma edges and moves chroma phase
// - phase zero moves to -1/4,0,1/4; half moves to 1/4,1/2,3/4
// - vertical up uses half-width line buffers, vertical down zeroes chroma of even lines, no multipliers
// - vertical resampling nearest-neighbor only, interlace not distinguished
// - samples are unsigned N-bit per plane in and out
// - 4:2:2 order Cb Y Cr Y; 4:4:4 order Cb Cr Y
`timescale 1ns/1ps
`default_nettype none
module crs_resampler #(
  parameter int MAX_W      = 1024,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [crs_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        s_valid,
  output logic                             s_ready,
  input  wire crs_pkg::crs_beat_t          s_beat,
  output logic                             m_valid,
  input  wire logic                        m_ready,
  output crs_pkg::crs_beat_t               m_beat
);
  import crs_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_PASS, ST_VID, ST_FILL} crs_state_t;
  localparam int LBA = $clog2(MAX_W / 2);

  // ---------------------------------------------------------------
  // filter helpers
  // ---------------------------------------------------------------
  function automatic logic [BPS-1:0] crs_sat(input crs_acc_t v, input int sh);
    crs_acc_t r;
    r = (v + (crs_acc_t'(1) <<< (sh - 1))) >>> sh;
    if (r < 0) return '0;
    else if (r > crs_acc_t'({BPS{1'b1}})) return '1;
    else return r[BPS-1:0];
  endfunction

  // nine taps: 16 centre, 9 at +-1, 0 at +-2 and +-4, -1 at +-3, over 32
  function automatic logic [BPS-1:0] crs_dec9(input logic [BPS-1:0] c, input logic [BPS-1:0] a1,
      input logic [BPS-1:0] b1, input logic [BPS-1:0] a3, input logic [BPS-1:0] b3);
    crs_acc_t s1;
    s1 = crs_acc_t'(a1) + crs_acc_t'(b1);
    return crs_sat((crs_acc_t'(c) <<< 4) + (s1 <<< 3) + s1 - crs_acc_t'(a3) - crs_acc_t'(b3),
                   DEC_SH);
  endfunction

  // four taps a,b,c,d at -1,0,1,2; result at q quarters past b
  function automatic logic [BPS-1:0] crs_tap4(input logic [BPS-1:0] a, input logic [BPS-1:0] b,
      input logic [BPS-1:0] c, input logic [BPS-1:0] d, input logic [1:0] q);
    crs_acc_t sa, sb, sc, sd, v;
    sa = crs_acc_t'(a);
    sb = crs_acc_t'(b);
    sc = crs_acc_t'(c);
    sd = crs_acc_t'(d);
    case (q)
      2'h1:    v = (sb <<< 3) + (sb <<< 2) + sb + (sc <<< 2) + sc - sa - sd;
      2'h2:    v = (sb <<< 3) + sb + (sc <<< 3) + sc - sa - sd;
      2'h3:    v = (sc <<< 3) + (sc <<< 2) + sc + (sb <<< 2) + sb - sa - sd;
      default: v = sb <<< INT_SH;
    endcase
    return crs_sat(v, INT_SH);
  endfunction

  function automatic logic [BPS-1:0] crs_absd(input logic [BPS-1:0] a, input logic [BPS-1:0] b);
    return (a > b) ? BPS'(a - b) : BPS'(b - a);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  crs_state_t      st_r, st_nxt;
  logic [7:0]      ctrl_r, ctrl_nxt, act_r, act_nxt;
  logic [15:0]     width_r, width_nxt, height_r, height_nxt;
  logic [15:0]     nw_r, nw_nxt, nh_r, nh_nxt, col_r, col_nxt;
  logic [3:0]      nib_r, nib_nxt;
  logic [31:0]     frames_r, frames_nxt, prdata_r, prdata_nxt;
  logic            pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  crs_beat_t       in_r, in_nxt, ob_r, ob_nxt, pix;
  logic            in_v_r, in_v_nxt, s_ready_r, s_ready_nxt, ov_r, ov_nxt;
  logic            lodd_r, lodd_nxt, last_r, last_nxt;
  logic [2:0]      fcnt_r, fcnt_nxt;
  logic [BPS-1:0]  crh_r, crh_nxt, crd, cbd, cbu, cru;
  crs_win_t        win_r [WIN];
  crs_win_t        win_nxt [WIN];
  crs_win_t        nw [WIN];
  crs_win_t        e [WIN];
  crs_win_t        ent;
  logic [BPS-1:0]  lbcb_r [MAX_W/2];
  logic [BPS-1:0]  lbcr_r [MAX_W/2];
  logic            lb_we, use_in, push, f_ready, wr_acc, emit;
  logic [LBA-1:0]  lb_idx;
  logic [1:0]      in_fmt, out_fmt, q;
  logic            h_down, h_up, v_up, v_down, okj;
  logic [1:0]      dir;
  logic [3:0]      nidx;

  assign in_fmt  = act_r[CTRL_IN+:2];
  assign out_fmt = act_r[CTRL_OUT+:2];
  assign h_down  = (in_fmt == FMT_444) && (out_fmt != FMT_444);
  assign h_up    = (in_fmt != FMT_444) && (out_fmt == FMT_444);
  assign v_up    = (in_fmt == FMT_420) && (out_fmt != FMT_420);
  assign v_down  = (out_fmt == FMT_420) && (in_fmt != FMT_420);
  assign lb_idx  = LBA'((col_r - 16'h0001) >> 1);

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  always_comb begin
    wr_acc      = psel && penable && pready_r && pwrite;
    pready_nxt  = psel && !penable && !pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    ctrl_nxt    = (wr_acc && paddr == REG_CTRL) ? pwdata[7:0] : ctrl_r;
    if (psel && !penable) begin
      case (paddr)
        REG_CTRL:   prdata_nxt = {24'h000000, ctrl_r};
        REG_STATUS: prdata_nxt = {29'h00000000, in_v_r, ov_r, st_r != ST_IDLE};
        REG_WIDTH:  prdata_nxt = {16'h0000, width_r};
        REG_HEIGHT: prdata_nxt = {16'h0000, height_r};
        REG_FRAMES: prdata_nxt = frames_r;
        default: begin
          prdata_nxt  = 32'h00000000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // window taps with edge replication and filters
  // ---------------------------------------------------------------
  always_comb begin
    for (int j = 0; j < WIN - 1; j++) nw[j] = win_r[j + 1];
    nw[WIN-1] = ent;
    e[CTR] = nw[CTR];
    for (int k = 1; k <= CTR; k++) begin
      okj = !nw[CTR-k].fill && (nw[CTR-k].ln == nw[CTR].ln);
      e[CTR-k] = okj ? nw[CTR-k] : (h_up && k >= 2) ? e[CTR-k+2] :
                 (h_up && !nw[CTR+1].fill) ? nw[CTR+1] : e[CTR-k+1];
      okj = !nw[CTR+k].fill && (nw[CTR+k].ln == nw[CTR].ln);
      e[CTR+k] = okj ? nw[CTR+k] : (h_up && k >= 2) ? e[CTR+k-2] :
                 (h_up && !nw[CTR-1].fill) ? nw[CTR-1] : e[CTR+k-1];
    end
    dir = 2'h0;
    if (act_r[CTRL_LUMA]) begin
      if (crs_absd(e[4].y, e[3].y) > 9'(crs_absd(e[5].y, e[4].y)) + EDGE_THR) dir = 2'h1;
      else if (crs_absd(e[5].y, e[4].y) > 9'(crs_absd(e[4].y, e[3].y)) + EDGE_THR) dir = 2'h3;
    end
    // down: filtered or nearest value at centre column
    cbd = act_r[CTRL_FILT] ? crs_dec9(e[4].cb, e[3].cb, e[5].cb, e[1].cb, e[7].cb) : e[4].cb;
    crd = act_r[CTRL_FILT] ? crs_dec9(e[4].cr, e[3].cr, e[5].cr, e[1].cr, e[7].cr) : e[4].cr;
    // up: cb field holds the single chroma plane of each beat
    q = 2'h2 + dir;
    if (!act_r[CTRL_FILT]) begin
      cbu = e[4].odd ? e[4].cb : e[3].cb;
      cru = e[4].odd ? e[5].cb : e[4].cb;
    end else if (e[4].odd) begin
      case (dir)
        2'h1: begin
          cbu = crs_tap4(e[2].cb, e[4].cb, e[6].cb, e[8].cb, 2'h1);
          cru = crs_tap4(e[3].cb, e[5].cb, e[7].cb, e[7].cb, 2'h1);
        end
        2'h3: begin
          cbu = crs_tap4(e[0].cb, e[2].cb, e[4].cb, e[6].cb, 2'h3);
          cru = crs_tap4(e[1].cb, e[3].cb, e[5].cb, e[7].cb, 2'h3);
        end
        default: begin
          cbu = e[4].cb;
          cru = e[5].cb;
        end
      endcase
    end else begin
      cbu = crs_tap4(e[1].cb, e[3].cb, e[5].cb, e[7].cb, q);
      cru = crs_tap4(e[2].cb, e[4].cb, e[6].cb, e[8].cb, q);
    end
    pix.sop = 1'b0;
    pix.eop = e[4].eop;
    if (h_down) begin
      pix.pl = {{BPS{1'b0}}, e[4].y, e[4].odd ? cbd : crh_r};
    end else if (h_up) begin
      pix.pl = {e[4].y, cru, cbu};
    end else if (in_fmt == FMT_444) begin
      pix.pl = {e[4].y, e[4].cr, e[4].cb};
    end else begin
      pix.pl = {{BPS{1'b0}}, e[4].y, e[4].cb};
    end
    if (v_down && !e[4].ln) pix.pl[0] = '0;
  end

  // ---------------------------------------------------------------
  // packet engine
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    act_nxt    = act_r;
    width_nxt  = width_r;
    height_nxt = height_r;
    nw_nxt     = nw_r;
    nh_nxt     = nh_r;
    nib_nxt    = nib_r;
    frames_nxt = frames_r;
    col_nxt    = col_r;
    lodd_nxt   = lodd_r;
    last_nxt   = last_r;
    fcnt_nxt   = fcnt_r;
    crh_nxt    = crh_r;
    ob_nxt     = ob_r;
    ov_nxt     = ov_r && !f_ready;
    use_in     = 1'b0;
    push       = 1'b0;
    emit       = (!ov_r || f_ready);
    lb_we      = 1'b0;
    nidx       = 4'h0;
    ent.fill   = 1'b0;
    ent.ln     = lodd_r;
    ent.eop    = in_r.eop;
    ent.odd    = col_r[0];
    ent.y      = (in_fmt == FMT_444) ? in_r.pl[2] : in_r.pl[1];
    ent.cb     = in_r.pl[0];
    ent.cr     = in_r.pl[1];
    if (v_up && !lodd_r) ent.cb = col_r[0] ? lbcb_r[lb_idx] : lbcr_r[lb_idx];
    if (v_up && lodd_r && st_r == ST_VID && in_v_r && emit) lb_we = 1'b1;
    case (st_r)
      ST_IDLE: begin
        if (in_v_r && emit && ctrl_r[CTRL_GO]) begin
          use_in = 1'b1;
          if (in_r.sop) begin
            ob_nxt = in_r;
            ov_nxt = 1'b1;
            if (in_r.pl[0][3:0] == PKT_VIDEO) begin
              act_nxt    = ctrl_r;
              col_nxt    = 16'h0001;
              lodd_nxt   = 1'b1;
              frames_nxt = frames_r + 32'h00000001;
            end
            nib_nxt = 4'h0;
            if (!in_r.eop) begin
              case (in_r.pl[0][3:0])
                PKT_VIDEO: st_nxt = ST_VID;
                PKT_CTRL:  st_nxt = ST_CTRL;
                default:   st_nxt = ST_PASS;
              endcase
            end
          end
        end
      end
      ST_CTRL, ST_PASS: begin
        if (in_v_r && emit) begin
          use_in = 1'b1;
          ob_nxt = in_r;
          ov_nxt = 1'b1;
          if (st_r == ST_CTRL) begin
            for (int k = 0; k < PLANES; k++) begin
              nidx = nib_r + 4'(k);
              if (nidx < NIB_W_END) nw_nxt = {nw_nxt[11:0], in_r.pl[k][3:0]};
              else if (nidx < NIB_H_END) nh_nxt = {nh_nxt[11:0], in_r.pl[k][3:0]};
            end
            nib_nxt = (nib_r >= NIB_LAST) ? nib_r : nib_r + 4'(PLANES);
          end
          if (in_r.eop) begin
            st_nxt = ST_IDLE;
            if (st_r == ST_CTRL && ctrl_r[CTRL_RTS] && nib_nxt >= NIB_H_END) begin
              width_nxt  = nw_nxt;
              height_nxt = nh_nxt;
            end
          end
        end
      end
      ST_VID: begin
        if (in_v_r && emit) begin
          use_in  = 1'b1;
          push    = 1'b1;
          col_nxt = col_r + 16'h0001;
          if (col_r >= width_r || in_r.eop) begin
            st_nxt   = ST_FILL;
            fcnt_nxt = FILLS;
            last_nxt = in_r.eop;
            col_nxt  = 16'h0001;
            lodd_nxt = !lodd_r;
          end
        end
      end
      ST_FILL: begin
        if (emit) begin
          push     = 1'b1;
          ent.fill = 1'b1;
          fcnt_nxt = fcnt_r - 3'h1;
          if (fcnt_r == 3'h1) st_nxt = last_r ? ST_IDLE : ST_VID;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    for (int j = 0; j < WIN; j++) win_nxt[j] = push ? nw[j] : win_r[j];
    if (push && !nw[CTR].fill) begin
      ob_nxt = pix;
      ov_nxt = 1'b1;
      if (h_down && nw[CTR].odd) crh_nxt = crd;
    end
    in_v_nxt    = (s_valid && s_ready_r) ? 1'b1 : (use_in ? 1'b0 : in_v_r);
    in_nxt      = (s_valid && s_ready_r) ? s_beat : in_r;
    s_ready_nxt = !in_v_nxt;
  end

  always_ff @(posedge pclk) begin
    if (lb_we && col_r[0]) lbcb_r[lb_idx] <= in_r.pl[0];
    if (lb_we && !col_r[0]) lbcr_r[lb_idx] <= in_r.pl[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= ST_IDLE;
      ctrl_r    <= CTRL_RST;
      act_r     <= CTRL_RST;
      width_r   <= DEF_WIDTH;
      height_r  <= DEF_HEIGHT;
      nw_r      <= '0;
      nh_r      <= '0;
      nib_r     <= '0;
      frames_r  <= '0;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      in_r      <= '0;
      in_v_r    <= 1'b0;
      s_ready_r <= 1'b0;
      ob_r      <= '0;
      ov_r      <= 1'b0;
      col_r     <= 16'h0001;
      lodd_r    <= 1'b1;
      last_r    <= 1'b0;
      fcnt_r    <= '0;
      crh_r     <= '0;
      for (int j = 0; j < WIN; j++) win_r[j] <= '{fill: 1'b1, default: '0};
    end else begin
      st_r      <= st_nxt;
      ctrl_r    <= ctrl_nxt;
      act_r     <= act_nxt;
      width_r   <= width_nxt;
      height_r  <= height_nxt;
      nw_r      <= nw_nxt;
      nh_r      <= nh_nxt;
      nib_r     <= nib_nxt;
      frames_r  <= frames_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      in_r      <= in_nxt;
      in_v_r    <= in_v_nxt;
      s_ready_r <= s_ready_nxt;
      ob_r      <= ob_nxt;
      ov_r      <= ov_nxt;
      col_r     <= col_nxt;
      lodd_r    <= lodd_nxt;
      last_r    <= last_nxt;
      fcnt_r    <= fcnt_nxt;
      crh_r     <= crh_nxt;
      for (int j = 0; j < WIN; j++) win_r[j] <= win_nxt[j];
    end
  end

  // ---------------------------------------------------------------
  // output buffering
  // ---------------------------------------------------------------
  crs_fifo #(
    .W     ($bits(crs_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (ov_r),
    .in_ready  (f_ready),
    .in_data   (ob_r),
    .out_valid (m_valid),
    .out_ready (m_ready),
    .out_data  (m_beat)
  );

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign s_ready = s_ready_r;
endmodule
`default_nettype wire

/* File: hdl/crs_pkg.sv */
// shared constants and types for the chroma resampler
package crs_pkg;
  // ---------------------------------------------------------------
  // sample and beat layout
  // ---------------------------------------------------------------
  localparam int BPS    = 8;
  localparam int PLANES = 3;
  localparam int ACC_W  = BPS + 9;
  localparam int WIN    = 9;
  localparam int CTR    = 4;
  localparam logic [2:0] FILLS = 3'h4;

  typedef logic signed [ACC_W-1:0] crs_acc_t;

  typedef struct packed {
    logic                         sop;
    logic                         eop;
    logic [PLANES-1:0][BPS-1:0]   pl;
  } crs_beat_t;

  typedef struct packed {
    logic           fill;
    logic           ln;
    logic           eop;
    logic           odd;
    logic [BPS-1:0] y;
    logic [BPS-1:0] cb;
    logic [BPS-1:0] cr;
  } crs_win_t;

  // ---------------------------------------------------------------
  // formats and packets
  // ---------------------------------------------------------------
  localparam logic [1:0] FMT_444   = 2'h0;
  localparam logic [1:0] FMT_422   = 2'h1;
  localparam logic [1:0] FMT_420   = 2'h2;
  localparam logic [3:0] PKT_VIDEO = 4'h0;
  localparam logic [3:0] PKT_CTRL  = 4'hF;
  localparam logic [3:0] NIB_W_END = 4'h4;
  localparam logic [3:0] NIB_H_END = 4'h8;
  localparam logic [3:0] NIB_LAST  = 4'h9;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_WIDTH  = 12'h008;
  localparam logic [11:0] REG_HEIGHT = 12'h00C;
  localparam logic [11:0] REG_FRAMES = 12'h010;
  localparam int          CTRL_GO    = 0;
  localparam int          CTRL_IN    = 1;
  localparam int          CTRL_OUT   = 3;
  localparam int          CTRL_FILT  = 5;
  localparam int          CTRL_LUMA  = 6;
  localparam int          CTRL_RTS   = 7;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] DEF_WIDTH  = 16'h0280;
  localparam logic [15:0] DEF_HEIGHT = 16'h01E0;

  // ---------------------------------------------------------------
  // filter scaling
  // ---------------------------------------------------------------
  localparam int             DEC_SH   = 5;
  localparam int             INT_SH   = 4;
  localparam logic [BPS-1:0] EDGE_THR = 8'h10;
endpackage

/* File: hdl/crs_fifo.sv */
// flop based fifo with registered output stage
`timescale 1ns/1ps
`default_nettype none
module crs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          rdy_r, rdy_nxt, ov_r, ov_nxt;
  logic [W-1:0]  od_r, od_nxt;
  logic          wr, rd;

  always_comb begin
    wr      = in_valid && rdy_r;
    rd      = (cnt_r != '0) && (!ov_r || out_ready);
    wp_nxt  = wr ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
    rp_nxt  = rd ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
    cnt_nxt = CW'(cnt_r + CW'(wr) - CW'(rd));
    rdy_nxt = cnt_nxt != CW'(DEPTH);
    ov_nxt  = rd ? 1'b1 : (ov_r && !out_ready);
    od_nxt  = rd ? mem_r[rp_r] : od_r;
  end

  always_ff @(posedge clk) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      ov_r  <= 1'b0;
      od_r  <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      ov_r  <= ov_nxt;
      od_r  <= od_nxt;
    end
  end

  assign in_ready  = rdy_r;
  assign out_valid = ov_r;
  assign out_data  = od_r;
endmodule
`default_nettype wire

/* File: tb/crs_resampler_checker.sv */
// port assertions for the chroma resampler
`timescale 1ns/1ps
`default_nettype none
module crs_resampler_checker (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [crs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       s_valid,
  input wire logic                       s_ready,
  input wire crs_pkg::crs_beat_t         s_beat,
  input wire logic                       m_valid,
  input wire logic                       m_ready,
  input wire crs_pkg::crs_beat_t         m_beat
);
  import crs_pkg::*;
  logic mapped;
  assign mapped = paddr <= REG_FRAMES && paddr[1:0] == 2'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
  property p_rdy_fast; psel && !penable |=> pready; endproperty
  a_rdy_fast: assert property (p_rdy_fast) else $error("no answer in access cycle");
  property p_rdy_qual; pready |-> psel && penable; endproperty
  a_rdy_qual: assert property (p_rdy_qual) else $error("pready outside access");
  property p_err_map; pready |-> pslverr == !mapped; endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_err_zero; pslverr |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("data on refused read");
  property p_ctrl_rsv; pready && !pwrite && paddr == REG_CTRL |-> prdata[31:8] == 24'h0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved control bits set");
  // ---------------------------------------------------------------
  // stream
  // ---------------------------------------------------------------
  property p_take; s_valid && s_ready |=> !s_ready; endproperty
  a_take: assert property (p_take) else $error("s_ready held after take");
  property p_hold; m_valid && !m_ready |=> m_valid && $stable(m_beat); endproperty
  a_hold: assert property (p_hold) else $error("output beat changed while stalled");
  c_hdr: cover property (s_valid && s_ready && s_beat.sop);
  c_stall: cover property (m_valid && !m_ready);
  c_err: cover property (pslverr);
endmodule
`default_nettype wire

/* File: tb/crs_sink_model.sv */
// downstream video sink with a stall pattern
`timescale 1ns/1ps
`default_nettype none
module crs_sink_model (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               hold,
  input wire logic               m_valid,
  output logic                   m_ready,
  input wire crs_pkg::crs_beat_t m_beat
);
  import crs_pkg::*;
  logic [23:0] pix[$];
  int          tot = 0;
  logic        vid = 1'b0;
  logic [1:0]  ph;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ready <= 1'b0;
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      m_ready <= !hold && ph != 2'h3;
      if (m_valid && m_ready) begin
        tot <= tot + 1;
        if (m_beat.sop)
          vid <= m_beat.pl[0][3:0] == PKT_VIDEO;
        else if (vid)
          pix.push_back(m_beat.pl);
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/crs_resampler_tb.sv */
// self-checking bench for the chroma resampler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (b)); end end
module crs_resampler_tb;
  import crs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, s_valid = 1'b0, s_ready, m_valid, m_ready, hold = 1'b0;
  crs_beat_t   s_beat = '0, m_beat;
  int          n_errors = 0, checks = 0, cyc = 0;
  logic [25:0] cpk[4] = '{26'h200000F, 26'h0, 26'h4, 26'h1000100};
  logic [23:0] v444[4] = '{24'h302010, 24'h312111, 24'h322212, 24'h332313};
  logic [23:0] v422[4] = '{24'h003010, 24'h003120, 24'h003212, 24'h003322};
  logic [23:0] vup[4] = '{24'h302010, 24'h312010, 24'h322212, 24'h332212};
  logic [7:0]  modes[7] = '{8'h81, 8'hA9, 8'hB1, 8'hA3, 8'hE3, 8'h91, 8'h85};
  crs_resampler u_crs_resampler (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .s_valid(s_valid), .s_ready(s_ready),
    .s_beat(s_beat), .m_valid(m_valid), .m_ready(m_ready), .m_beat(m_beat));
  crs_sink_model u_crs_sink_model (.pclk(pclk), .presetn(presetn), .hold(hold),
    .m_valid(m_valid), .m_ready(m_ready), .m_beat(m_beat));
  initial forever #12.5 pclk = ~pclk;
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk_rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  task snd(input logic s, input logic e, input logic [23:0] p, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    s_valid <= 1'b1;
    s_beat <= crs_beat_t'({s, e, p});
    do begin @(posedge pclk); n++; end while (s_ready !== 1'b1 && n < 40);
    ok = s_ready === 1'b1;
    s_valid <= 1'b0;
  endtask
  // control packet: width 4, height 1
  task ctl(output int k);
    logic ok;
    k = 0;
    foreach (cpk[i]) begin
      snd(cpk[i][25], cpk[i][24], cpk[i][23:0], ok);
      k += int'(ok);
    end
  endtask
  task frame(input logic [7:0] c, input logic [23:0] pi[4], input logic [23:0] po[4]);
    logic [31:0] r;
    logic        ok;
    int          k, b;
    apb(1'b1, REG_CTRL, {24'h0, c}, r, ok);
    ctl(k);
    b = u_crs_sink_model.pix.size();
    snd(1'b1, 1'b0, 24'h0, ok);
    for (int i = 0; i < 4; i++) snd(1'b0, i == 3, pi[i], ok);
    k = 0;
    while (u_crs_sink_model.pix.size() < b + 4 && k < 300) begin @(posedge pclk); k++; end
    for (int i = 0; i < 4; i++) `CHK(u_crs_sink_model.pix[b + i], po[i])
    chk_rd(REG_WIDTH, 32'h4, 1'b0);
    chk_rd(REG_HEIGHT, 32'h1, 1'b0);
  endtask
  // flat chroma, luma step mid-line: every filter and phase must keep chroma
  task cst(input logic [7:0] c);
    logic [23:0] a[4], z[4];
    for (int i = 0; i < 4; i++) begin
      a[i] = c[2:1] == FMT_444 ? {i[1] ? 8'hF0 : 8'h10, 8'h80, 8'h40}
                               : {8'h0, i[1] ? 8'hF0 : 8'h10, i[0] ? 8'h80 : 8'h40};
      z[i] = c[4:3] == FMT_444 ? {i[1] ? 8'hF0 : 8'h10, 8'h80, 8'h40}
                               : {8'h0, i[1] ? 8'hF0 : 8'h10, i[0] ? 8'h80 : 8'h40};
    end
    frame(c, a, z);
  endtask
  task fill;
    int k, t, b;
    t = 0;
    hold <= 1'b1;
    b = u_crs_sink_model.tot;
    repeat (12) begin
      ctl(k);
      t += k;
    end
    `CHK(t < 48, 1'b1)
    hold <= 1'b0;
    k = 0;
    while (u_crs_sink_model.tot < b + 32 && k < 400) begin @(posedge pclk); k++; end
    `CHK(u_crs_sink_model.tot >= b + 32, 1'b1)
  endtask
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(REG_CTRL, 32'h0, 1'b0);
    chk_rd(REG_WIDTH, {16'h0, DEF_WIDTH}, 1'b0);
    apb(1'b1, REG_HEIGHT, 32'h123, r, e);
    chk_rd(REG_HEIGHT, {16'h0, DEF_HEIGHT}, 1'b0);
    chk_rd(12'h014, 32'h0, 1'b1);
    frame(8'h89, v444, v422);
    frame(8'h83, v422, vup);
    foreach (modes[i]) cst(modes[i]);
    fill();
    tally_and_finish();
  end
endmodule
bind crs_resampler crs_resampler_checker u_crs_resampler_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .s_valid(s_valid),
  .s_ready(s_ready), .s_beat(s_beat), .m_valid(m_valid), .m_ready(m_ready),
  .m_beat(m_beat));
`default_nettype wire
